/* hdl/prt_timer.v */
// Prescaled 8-bit down-counting reload timer with Avalon-MM register slave.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "prt_map.vh"
module prt_timer (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	output reg avs_response_ok_n_o,
	input wire count_clk_i,
	input wire companion_uflow_i,
	output reg timer_out_o,
	output reg underflow_o
);
	// ======================================================================
	// Registers
	// ======================================================================
	reg count_start_bit_ff;
	reg counting_status_flag_ff;
	reg forced_stop_bit_ff;
	reg oneshot_status_flag_ff;
	reg [7:0] io_control_reg_ff;
	reg [7:0] mode_reg_ff;
	reg [7:0] prescaler_reg_ff;
	reg [7:0] primary_period_reg_ff;
	reg [7:0] secondary_period_reg_ff;
	reg [7:0] presc_cnt_ff;
	reg [7:0] main_cnt_ff;
	reg [1:0] start_sync_ff;
	reg [1:0] os_sync_ff;
	reg os_req_ff;
	reg os_target_ff;
	reg os_armed_ff;
	reg phase_sec_ff;
	reg ack_ff;
	wire src_rise;
	wire src_edge;
	wire [1:0] mode;
	wire oneshot_mode;
	wire wr_hit;
	wire rd_hit;
	wire be0;
	wire presc_uf;
	wire main_uf;
	wire [7:0] reload_val;
	wire halt_req;

	// Outside count source is synchronised before edge detection.
	prt_edge_sync u_src_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.sig_i(count_clk_i),
		.rise_o(src_rise)
	);

	// Companion underflow comes from logic on this clock and needs no synchroniser.
	assign src_edge = mode_reg_ff[`PRT_MODE_SRC] ? companion_uflow_i : src_rise;
	assign mode = mode_reg_ff[`PRT_MODE_HI:`PRT_MODE_LO];
	assign oneshot_mode = (mode == `PRT_MODE_ONESHOT) || (mode == `PRT_MODE_WAIT);
	assign wr_hit = avs_write_i && !ack_ff;
	assign rd_hit = avs_read_i && !ack_ff;
	assign be0 = avs_byteenable_i[0];
	assign presc_uf = src_edge && (presc_cnt_ff == 8'h00);
	assign main_uf = presc_uf && (main_cnt_ff == 8'h00);
	// Waveform mode alternates primary and secondary periods.
	assign reload_val = (mode == `PRT_MODE_WAVE && !phase_sec_ff) ? secondary_period_reg_ff :
		primary_period_reg_ff;
	// One-shot halt when start is withdrawn or one-shot stop is written.
	assign halt_req = oneshot_mode && ((!count_start_bit_ff && counting_status_flag_ff) ||
		(wr_hit && be0 && avs_address_i == `PRT_OFS_ONESHOT &&
		avs_writedata_i[`PRT_OS_STOP]));

	function [7:0] merge;
		input [7:0] old;
		input [7:0] nw;
		input en;
		begin
			merge = en ? nw : old;
		end
	endfunction

	// ======================================================================
	// Avalon-MM slave: one wait cycle, then answer.
	// ======================================================================
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_ff <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
			avs_response_ok_n_o <= 1'b0;
		end else begin
			ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_ff);
			avs_response_ok_n_o <= (avs_read_i || avs_write_i) && !ack_ff &&
				(avs_address_i > `PRT_OFS_PRIMARY);
			if (rd_hit) begin
				case (avs_address_i)
				`PRT_OFS_CTRL: avs_readdata_o <= {29'h0, forced_stop_bit_ff,
					counting_status_flag_ff, count_start_bit_ff};
				`PRT_OFS_ONESHOT: avs_readdata_o <= {29'h0, oneshot_status_flag_ff, 2'h0};
				`PRT_OFS_IOCTL: avs_readdata_o <= {24'h0, io_control_reg_ff};
				`PRT_OFS_MODE: avs_readdata_o <= {24'h0, mode_reg_ff};
				// Each byte is its own word, so a 16-bit pair is two reads.
				`PRT_OFS_PRESC: avs_readdata_o <= {24'h0, presc_cnt_ff};
				`PRT_OFS_SECOND: avs_readdata_o <= {24'h0, secondary_period_reg_ff};
				`PRT_OFS_PRIMARY: avs_readdata_o <= {24'h0, main_cnt_ff};
				default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ======================================================================
	// Control and reload registers
	// ======================================================================
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_start_bit_ff <= 1'b0;
			forced_stop_bit_ff <= 1'b0;
			io_control_reg_ff <= `PRT_RST_ZERO;
			mode_reg_ff <= `PRT_RST_ZERO;
			prescaler_reg_ff <= `PRT_RST_BYTE;
			primary_period_reg_ff <= `PRT_RST_BYTE;
			secondary_period_reg_ff <= `PRT_RST_BYTE;
		end else begin
			if (wr_hit) begin
				case (avs_address_i)
				`PRT_OFS_CTRL: if (be0) begin
					count_start_bit_ff <= avs_writedata_i[`PRT_CTRL_START] &&
						!avs_writedata_i[`PRT_CTRL_FSTOP];
					forced_stop_bit_ff <= avs_writedata_i[`PRT_CTRL_FSTOP];
				end
				`PRT_OFS_IOCTL: io_control_reg_ff <= merge(io_control_reg_ff,
					avs_writedata_i[7:0], be0);
				`PRT_OFS_MODE: mode_reg_ff <= merge(mode_reg_ff, avs_writedata_i[7:0], be0);
				// Software spaces these writes; no guard here.
				`PRT_OFS_PRESC: prescaler_reg_ff <= merge(prescaler_reg_ff,
					avs_writedata_i[7:0], be0);
				`PRT_OFS_SECOND: secondary_period_reg_ff <= merge(secondary_period_reg_ff,
					avs_writedata_i[7:0], be0);
				`PRT_OFS_PRIMARY: primary_period_reg_ff <= merge(primary_period_reg_ff,
					avs_writedata_i[7:0], be0);
				default: ;
				endcase
			end else if (oneshot_mode && counting_status_flag_ff && main_uf &&
				mode == `PRT_MODE_ONESHOT) begin
				count_start_bit_ff <= count_start_bit_ff;
			end
		end
	end

	// ======================================================================
	// Start/stop synchronisation, prescaler and counter
	// ======================================================================
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			counting_status_flag_ff <= 1'b0;
			start_sync_ff <= 2'h0;
			presc_cnt_ff <= `PRT_RST_BYTE;
			main_cnt_ff <= `PRT_RST_BYTE;
			phase_sec_ff <= 1'b0;
			timer_out_o <= 1'b0;
			underflow_o <= 1'b0;
		end else begin
			underflow_o <= 1'b0;
			if (forced_stop_bit_ff) begin
				counting_status_flag_ff <= 1'b0;
				start_sync_ff <= 2'h0;
				presc_cnt_ff <= prescaler_reg_ff;
				main_cnt_ff <= primary_period_reg_ff;
			end else if (count_start_bit_ff != counting_status_flag_ff) begin
				// Request settles after two source edges; the first may land late.
				if (src_edge) begin
					if (start_sync_ff == `PRT_SYNC_EDGES - 2'h1) begin
						counting_status_flag_ff <= count_start_bit_ff;
						start_sync_ff <= 2'h0;
						if (halt_req) begin
							presc_cnt_ff <= prescaler_reg_ff;
							main_cnt_ff <= primary_period_reg_ff;
						end
					end else
						start_sync_ff <= start_sync_ff + 2'h1;
				end
			end else begin
				start_sync_ff <= 2'h0;
				if (counting_status_flag_ff && halt_req && !count_start_bit_ff) begin
					presc_cnt_ff <= prescaler_reg_ff;
				end else if (oneshot_mode && halt_req) begin
					presc_cnt_ff <= prescaler_reg_ff;
					main_cnt_ff <= primary_period_reg_ff;
				end else if (wr_hit && be0 && avs_address_i == `PRT_OFS_PRESC &&
					!counting_status_flag_ff) begin
					presc_cnt_ff <= avs_writedata_i[7:0];
				end else if (wr_hit && be0 && avs_address_i == `PRT_OFS_PRIMARY &&
					!counting_status_flag_ff) begin
					main_cnt_ff <= avs_writedata_i[7:0];
				end else if (counting_status_flag_ff && src_edge &&
					(!oneshot_mode || oneshot_status_flag_ff)) begin
					presc_cnt_ff <= presc_uf ? prescaler_reg_ff : presc_cnt_ff - 8'h01;
					if (presc_uf) begin
						if (main_uf) begin
							main_cnt_ff <= reload_val;
							underflow_o <= 1'b1;
							phase_sec_ff <= !phase_sec_ff;
							timer_out_o <= (mode == `PRT_MODE_WAVE) ? phase_sec_ff :
								!timer_out_o;
						end else
							main_cnt_ff <= main_cnt_ff - 8'h01;
					end
				end
			end
		end
	end

	// ======================================================================
	// One-shot status: a trigger or stop lands after two source edges.
	// ======================================================================
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			oneshot_status_flag_ff <= 1'b0;
			os_sync_ff <= 2'h0;
			os_req_ff <= 1'b0;
			os_target_ff <= 1'b0;
			os_armed_ff <= 1'b0;
		end else begin
			if (wr_hit && be0 && avs_address_i == `PRT_OFS_ONESHOT &&
				(avs_writedata_i[`PRT_OS_TRIG] || avs_writedata_i[`PRT_OS_STOP])) begin
				// Latest request wins; either outcome of a crossing is allowed.
				os_req_ff <= 1'b1;
				os_target_ff <= !avs_writedata_i[`PRT_OS_STOP];
				os_sync_ff <= 2'h0;
			end else if (os_req_ff && src_edge) begin
				if (os_sync_ff == `PRT_SYNC_EDGES - 2'h1) begin
					oneshot_status_flag_ff <= os_target_ff && counting_status_flag_ff;
					os_armed_ff <= os_target_ff;
					os_req_ff <= 1'b0;
					os_sync_ff <= 2'h0;
				end else
					os_sync_ff <= os_sync_ff + 2'h1;
			end else if (oneshot_status_flag_ff && (main_uf || !counting_status_flag_ff)) begin
				oneshot_status_flag_ff <= 1'b0;
				os_armed_ff <= 1'b0;
			end
		end
	end
endmodule

/* hdl/prt_map.vh */
// Register map, field positions, reset values and timing counts of the reload timer.
`ifndef PRT_MAP_VH
`define PRT_MAP_VH
// ==========================================================================
// Word offsets (word addresses on a 32-bit Avalon-MM slave)
// ==========================================================================
`define PRT_ADDR_W 4
`define PRT_OFS_CTRL 4'h0
`define PRT_OFS_ONESHOT 4'h1
`define PRT_OFS_IOCTL 4'h2
`define PRT_OFS_MODE 4'h3
`define PRT_OFS_PRESC 4'h4
`define PRT_OFS_SECOND 4'h5
`define PRT_OFS_PRIMARY 4'h6
// ==========================================================================
// Field positions
// ==========================================================================
`define PRT_CTRL_START 0
`define PRT_CTRL_STATUS 1
`define PRT_CTRL_FSTOP 2
`define PRT_OS_TRIG 0
`define PRT_OS_STOP 1
`define PRT_OS_STATUS 2
`define PRT_MODE_LO 0
`define PRT_MODE_HI 1
`define PRT_MODE_SRC 4
// ==========================================================================
// Modes and reset values
// ==========================================================================
`define PRT_MODE_TIMER 2'h0
`define PRT_MODE_WAVE 2'h1
`define PRT_MODE_ONESHOT 2'h2
`define PRT_MODE_WAIT 2'h3
`define PRT_RST_BYTE 8'hff
`define PRT_RST_ZERO 8'h00
// Synchroniser depth for a start or stop request, in count source edges.
`define PRT_SYNC_EDGES 2'h2
`endif

/* hdl/prt_edge_sync.v */
// Three-flop synchroniser and rising-edge detector for an outside count source.
`timescale 1ns/100ps
module prt_edge_sync (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire sig_i,
	output reg rise_o
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	reg lvl_ff;

	// A change counts only when the second and third stages agree.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			lvl_ff <= 1'b0;
			rise_o <= 1'b0;
		end else begin
			s1_ff <= sig_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				lvl_ff <= s3_ff;
			rise_o <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
		end
	end
endmodule

/* bench/prt_timer_checker.sv */
// Bus and start-up assertions on the ports of the reload timer.
`timescale 1ns/100ps
module prt_timer_checker (
	input logic clk_sys_i,
	input logic rst_n_i,
	input logic [3:0] avs_address_i,
	input logic avs_read_i,
	input logic avs_write_i,
	input logic [31:0] avs_writedata_i,
	input logic [3:0] avs_byteenable_i,
	input logic [31:0] avs_readdata_o,
	input logic avs_waitrequest_o,
	input logic avs_response_ok_n_o,
	input logic underflow_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// Helper logic
	// ==========================================================
	logic started_ff;
	wire req_w = avs_read_i || avs_write_i;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			started_ff <= 1'b0;
		end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0
			&& avs_writedata_i[0] && avs_byteenable_i[0]) begin
			started_ff <= 1'b1;
		end
	end
	sequence s_taken;
		req_w && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	// ==========================================================
	// Assertions
	// ==========================================================
	chk_bus_answer: assert property (s_taken |=> s_answer)
		else $error("answer not one cycle after request");
	chk_answer_cause: assert property (!avs_waitrequest_o |-> $past(req_w))
		else $error("answer without request");
	chk_unmapped_resp: assert property (!avs_waitrequest_o && avs_address_i > 4'h6
		|-> avs_response_ok_n_o) else $error("unmapped address not flagged");
	chk_mapped_resp: assert property (!avs_waitrequest_o && avs_address_i <= 4'h6
		|-> !avs_response_ok_n_o) else $error("mapped address flagged");
	chk_unmapped_zero: assert property (!avs_waitrequest_o && avs_read_i
		&& avs_address_i > 4'h6 |-> avs_readdata_o == 32'h0) else $error("unmapped data");
	chk_read_hold: assert property (!$stable(avs_readdata_o) |-> !avs_waitrequest_o
		&& avs_read_i) else $error("read data moved outside a read");
	chk_no_early_count: assert property (!started_ff |-> !underflow_o)
		else $error("underflow before start");
	chk_write_slot: assert property (avs_write_i && avs_read_i |-> avs_waitrequest_o)
		else $error("answer to illegal request");
endmodule
bind prt_timer prt_timer_checker chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.avs_response_ok_n_o(avs_response_ok_n_o), .underflow_o(underflow_o));

/* bench/prt_timer_tb_top.sv */
// Register-level testbench of the reload timer.
`timescale 1ns/100ps
`include "prt_map.vh"
module prt_timer_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] adr = 4'h0;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] be = 4'hf;
	logic [31:0] rdata;
	logic wait_s, okn, tout, uf;
	logic cmp_uf = 1'b0;
	logic pin_s = 1'b0;
	int uf_cnt = 0;
	int mismatches = 0;
	int samples_checked = 0;
	prt_timer dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
		.avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_s),
		.avs_response_ok_n_o(okn), .count_clk_i(pin_s), .companion_uflow_i(cmp_uf),
		.timer_out_o(tout), .underflow_o(uf));
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Underflow is a one-cycle pulse, so it is counted rather than sampled.
	always @(posedge clk_sys_i) begin
		if (uf === 1'b1) begin
			uf_cnt <= uf_cnt + 1;
		end
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One Avalon transfer; the request is held until waitrequest is sampled low.
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		adr <= a;
		wd <= {24'h0, d};
		rd_s <= !w;
		wr_s <= w;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_s !== 1'b0 && n < 200);
		q = rdata[7:0];
		if (n >= 200) begin
			mismatches++;
		end
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
		logic [7:0] q;
		acc(1'b0, a, 8'h0, q);
		chk(nm, q, exp);
	endtask
	// The companion underflow is the count source in every scenario below except the pin source test.
	task automatic pulses(input int n);
		repeat (n) begin
			cmp_uf <= 1'b1;
			@(posedge clk_sys_i);
			cmp_uf <= 1'b0;
			repeat (4) @(posedge clk_sys_i);
		end
	endtask
	// Slow pin edges, long enough to pass the three-flop synchroniser.
	task automatic pin_pulses(input int n);
		repeat (n) begin
			pin_s <= 1'b1;
			repeat (6) @(posedge clk_sys_i);
			pin_s <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
		end
	endtask
	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rd("ctrl", `PRT_OFS_CTRL, 8'h00);
		rd("presc", `PRT_OFS_PRESC, `PRT_RST_BYTE);
		rd("unmapped", 4'h9, 8'h00);
		wr(`PRT_OFS_MODE, 8'h10);
		wr(`PRT_OFS_PRESC, 8'h02);
		wr(`PRT_OFS_PRIMARY, 8'h04);
		be <= 4'h0;
		wr(`PRT_OFS_PRESC, 8'h07);
		be <= 4'hf;
		rd("presc be0", `PRT_OFS_PRESC, 8'h02);
		$display("test reset done");
		wr(`PRT_OFS_CTRL, 8'h01);
		rd("sync lo", `PRT_OFS_CTRL, 8'h01);
		pulses(2);
		rd("sync hi", `PRT_OFS_CTRL, 8'h03);
		rd("no count", `PRT_OFS_PRESC, 8'h02);
		pulses(1);
		rd("presc dec", `PRT_OFS_PRESC, 8'h01);
		pulses(2);
		rd("presc rel", `PRT_OFS_PRESC, 8'h02);
		rd("cnt dec", `PRT_OFS_PRIMARY, 8'h03);
		$display("test start done");
		wr(`PRT_OFS_CTRL, 8'h00);
		rd("stop hold", `PRT_OFS_CTRL, 8'h02);
		pulses(2);
		rd("stop lo", `PRT_OFS_CTRL, 8'h00);
		pulses(3);
		rd("cnt frozen", `PRT_OFS_PRIMARY, 8'h03);
		$display("test stop done");
		wr(`PRT_OFS_CTRL, 8'h01);
		pulses(2);
		wr(`PRT_OFS_CTRL, 8'h05);
		rd("fstop", `PRT_OFS_CTRL, 8'h04);
		rd("fstop rel", `PRT_OFS_PRIMARY, 8'h04);
		wr(`PRT_OFS_CTRL, 8'h00);
		$display("test forced stop done");
		wr(`PRT_OFS_MODE, 8'h12);
		wr(`PRT_OFS_CTRL, 8'h01);
		pulses(2);
		wr(`PRT_OFS_ONESHOT, 8'h01);
		rd("os wait", `PRT_OFS_ONESHOT, 8'h00);
		pulses(2);
		rd("os set", `PRT_OFS_ONESHOT, 8'h04);
		pulses(3);
		wr(`PRT_OFS_ONESHOT, 8'h02);
		pulses(2);
		rd("os clr", `PRT_OFS_ONESHOT, 8'h00);
		rd("os rel", `PRT_OFS_PRIMARY, 8'h04);
		$display("test oneshot done");
		wr(`PRT_OFS_CTRL, 8'h00);
		pulses(2);
		wr(`PRT_OFS_MODE, 8'h00);
		wr(`PRT_OFS_PRESC, 8'h00);
		wr(`PRT_OFS_PRIMARY, 8'h01);
		chk("out idle", {7'h0, tout}, 8'h00);
		wr(`PRT_OFS_CTRL, 8'h01);
		pin_pulses(2);
		rd("pin sync", `PRT_OFS_CTRL, 8'h03);
		pin_pulses(2);
		chk("uf count", uf_cnt[7:0], 8'h01);
		chk("out set", {7'h0, tout}, 8'h01);
		pin_pulses(2);
		chk("uf again", uf_cnt[7:0], 8'h02);
		chk("out clr", {7'h0, tout}, 8'h00);
		$display("test pin source done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		stop_test();
	end
endmodule
